//--- verilog/sfic_pkg.sv
// Notes on behaviour
// [R1] Three-bit select routes one of eight analog inputs to the measurement path.
// [R2] Host sets gain 1x for voltage inputs, 18x sense node, 9.5x switches.
// [R3] Host sets calibration disable only above 100 mV or 200 mV, else 0.
// [R4] Hot-die warning from the temperature monitor raises its event flag.
// [R5] Shutdown temperature disables all rails and sets the thermal flag.
// [R6] Rails resume when temperature recovers; mirror enable untouched by thermal fault.
// [R7] Low cell voltage raises its warning flag; operation continues normally.
// [R8] Undervoltage lockout flags, drops rails, clears mirror enable, enters standby.
// [R9] Rails stay off until lockout clears and power request is toggled.
// [R10] Mirror rail fault flags, clears mirror enable, stops regulator and LED driver.
// [R11] Six-volt rail failure flags and disables LED driver, which retries itself.
// [R12] LED supply overvoltage sets its flag; buck-boost keeps running.
// [R13] Any event sets its flag and pulls the request pin low.
// [R14] Reading the flag register clears fault bits and releases the pin.
// [R15] Persisting fault keeps its flag; pin pulled low again within 32 us.
// [R16] Mask only stops the pin; flags and protection act unchanged.
// [R17] Host masks persistent events, polls flags, unmasks after fault clears.
// [R18] Chip select low for transfers; high ignores input, output high impedance.
// [R19] Input sampled on rising serial clock, output shifted on falling edge.
// [R20] First byte is command: top bit write when 1, seven address bits.
// [R21] Address increments after each data byte while chip select stays low.
// [R22] Address pointer wraps from top address back to zero.
// [R23] Power request low: off mode, registers at defaults, SPI ignored.
// [R24] Mirror enable resets to 1; once cleared, only a request toggle restores it.
// [R25] Bytes shift most significant bit first, eight clocks per byte.
package sfic_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_PERIOD_NS  = 40;
    localparam int REARM_TIME_US  = 32;
    localparam int REARM_CYC      = (REARM_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int REARM_W        = $clog2(REARM_CYC + 1);
    localparam int SYNC_W         = 11;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [6:0] ADDR_ENABLE = 7'h01;
    localparam logic [6:0] ADDR_AFE    = 7'h0a;
    localparam logic [6:0] ADDR_FLAGS  = 7'h0c;
    localparam logic [6:0] ADDR_MASK   = 7'h0d;

    localparam int WNR_BIT        = 7;
    localparam int ENA_LED_BIT    = 0;
    localparam int ENA_MIRROR_BIT = 1;
    localparam logic [2:0] LAST_BIT = 3'h7;

    localparam logic       LED_EN_RST    = 1'b1;
    localparam logic       MIRROR_EN_RST = 1'b1;
    localparam logic [5:0] AFE_RST       = 6'h00;
    localparam logic [6:0] MASK_RST      = 7'h00;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [2:0] SEL_PROBE_B  = 3'h0;
    localparam logic [2:0] SEL_LED_SUP  = 3'h1;
    localparam logic [2:0] SEL_BATTERY  = 3'h2;
    localparam logic [2:0] SEL_PROBE_A  = 3'h3;
    localparam logic [2:0] SEL_SENSE    = 3'h4;
    localparam logic [2:0] SEL_SWITCH_A = 3'h5;
    localparam logic [2:0] SEL_SWITCH_B = 3'h6;
    localparam logic [2:0] SEL_SWITCH_C = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic led_supply_overvoltage;
        logic six_volt_power_fail;
        logic mirror_rail_fault;
        logic supply_undervoltage_lockout;
        logic cell_voltage_warning;
        logic thermal_shutdown_flag;
        logic hot_die_warning;
    } sfic_evt_t;

    typedef struct packed {
        logic       offset_calibration_disable;
        logic [1:0] amplifier_gain;
        logic [2:0] measure_input_select;
    } sfic_afe_t;

    typedef enum logic [3:0] {
        MODE_OFF     = 4'h1,
        MODE_STANDBY = 4'h2,
        MODE_ACTIVE1 = 4'h4,
        MODE_ACTIVE2 = 4'h8
    } sfic_mode_t;

endpackage

//--- verilog/sfic_sync.sv
`timescale 1ns/1ps
module sfic_sync
    import sfic_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

//--- verilog/sfic_sel_decode.sv
`timescale 1ns/1ps
module sfic_sel_decode
    import sfic_pkg::*;
(
    // Select code
    input  wire logic [2:0] sel_in,
    // One line per measured input
    output logic      [7:0] onehot_out
);

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_ch
            assign onehot_out[i] = (sel_in == 3'(i)); // [R1]
        end
    endgenerate

endmodule

//--- verilog/spi_fault_interrupt_control.sv
`timescale 1ns/1ps
module spi_fault_interrupt_control
    import sfic_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // Serial port pins
    input  wire logic       chip_select_n_in,
    input  wire logic       spi_clk_in,
    input  wire logic       spi_din_in,
    output logic            spi_dout_out,
    output logic            spi_dout_oe_out,
    // Power request pin
    input  wire logic       projector_power_request_in,
    // Protection monitor comparators
    input  wire sfic_evt_t  monitor_events_in,
    // Open-drain event request pin
    output logic            event_request_pin_n_out,
    output logic            event_request_pin_n_oe_out,
    // Power control
    output logic            mirror_rails_enable_out,
    output logic            mirror_rails_on_out,
    output logic            led_driver_on_out,
    output sfic_mode_t      mode_out,
    // Measurement path
    output logic [7:0]      measure_channel_out,
    output sfic_afe_t       afe_config_out,
    // Status
    output sfic_evt_t       event_flags_out,
    output sfic_evt_t       event_mask_out
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and serial clock edges
    logic [SYNC_W-1:0] sync_w;
    logic              cs_n_s, sclk_s, din_s, ppr_s;
    sfic_evt_t         evt_s;
    logic              sclk_d_r;

    sfic_sync #(.W(SYNC_W)) u_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .async_in ({chip_select_n_in, spi_clk_in, spi_din_in,
                    projector_power_request_in, monitor_events_in}),
        .sync_out (sync_w)
    );

    assign {cs_n_s, sclk_s, din_s, ppr_s} = sync_w[10:7];
    assign evt_s     = sfic_evt_t'(sync_w[6:0]);

    wire off_mode   = ~ppr_s;                         // [R23]
    wire cs_act     = ~cs_n_s & ~off_mode;            // [R18]
    wire sclk_rise  = sclk_s & ~sclk_d_r;
    wire sclk_fall  = ~sclk_s & sclk_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic       led_en_r, mirror_en_r;
    sfic_afe_t  afe_r;
    sfic_evt_t  flags_r, mask_r;
    logic [REARM_W-1:0] holdoff_r;
    logic       irq_r, rails_r, led_r;
    sfic_mode_t mode_r;
    logic [7:0] chan_r;

    function automatic logic [7:0] rd_data(input logic [6:0] a,
                                           input logic led_en,
                                           input logic mir_en,
                                           input sfic_afe_t afe,
                                           input sfic_evt_t flg,
                                           input sfic_evt_t msk);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_ENABLE: d = {6'h00, mir_en, led_en};
            ADDR_AFE:    d = {2'h0, afe};
            ADDR_FLAGS:  d = {1'b0, flg};
            ADDR_MASK:   d = {1'b0, msk};
            default:     d = 8'h00;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial engine
    logic [2:0] bit_cnt_r;
    logic [6:0] rx_r;
    logic       cmd_r, wnr_r;
    logic [6:0] addr_r;
    logic [7:0] tx_r;
    logic       dout_r;

    wire [7:0] rx_byte   = {rx_r, din_s};                            // [R25]
    wire       byte_done = cs_act & sclk_rise & (bit_cnt_r == LAST_BIT);
    wire [6:0] ld_addr   = cmd_r ? rx_byte[6:0] : addr_r;            // [R20]
    wire       is_wr     = cmd_r ? rx_byte[WNR_BIT] : wnr_r;         // [R20]
    wire       rd_load   = byte_done & ~is_wr;
    wire       wr_stb    = byte_done & ~cmd_r & wnr_r;
    wire       int_rd    = rd_load & (ld_addr == ADDR_FLAGS);
    wire [6:0] addr_inc  = 7'(ld_addr + 7'h01);                      // [R22]
    wire [6:0] addr_nxt  = (cmd_r & is_wr) ? ld_addr : addr_inc;     // [R21]
    wire [7:0] rd_w      = rd_data(ld_addr, led_en_r, mirror_en_r,
                                   afe_r, flags_r, mask_r);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sclk_d_r  <= 1'b0;
            bit_cnt_r <= 3'h0;
            rx_r      <= 7'h00;
            cmd_r     <= 1'b1;
            wnr_r     <= 1'b0;
            addr_r    <= 7'h00;
        end else begin
            sclk_d_r <= sclk_s;
            if (!cs_act) begin                                       // [R18]
                bit_cnt_r <= 3'h0;
                cmd_r     <= 1'b1;
            end else if (sclk_rise) begin                            // [R19]
                rx_r      <= rx_byte[6:0];
                bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
                if (byte_done) begin
                    cmd_r  <= 1'b0;
                    wnr_r  <= is_wr;
                    addr_r <= addr_nxt;                              // [R21]
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_r   <= 8'h00;
            dout_r <= 1'b0;
        end else if (!cs_act) begin
            tx_r   <= 8'h00;
            dout_r <= 1'b0;
        end else if (rd_load) begin
            tx_r   <= rd_w;
        end else if (sclk_fall) begin                                // [R19]
            dout_r <= tx_r[7];                                       // [R25]
            tx_r   <= {tx_r[6:0], 1'b0};
        end
    end

    assign spi_dout_out    = dout_r;
    assign spi_dout_oe_out = cs_act;                                 // [R18]

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    wire wr_ena  = wr_stb & (addr_r == ADDR_ENABLE);
    wire wr_afe  = wr_stb & (addr_r == ADDR_AFE);
    wire wr_mask = wr_stb & (addr_r == ADDR_MASK);
    wire mir_clr = evt_s.supply_undervoltage_lockout                 // [R8]
                 | evt_s.mirror_rail_fault                           // [R10]
                 | (wr_ena & ~rx_byte[ENA_MIRROR_BIT]);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            led_en_r    <= LED_EN_RST;
            mirror_en_r <= MIRROR_EN_RST;
            afe_r       <= sfic_afe_t'(AFE_RST);
            mask_r      <= sfic_evt_t'(MASK_RST);
        end else if (off_mode) begin                                 // [R23]
            led_en_r    <= LED_EN_RST;
            mirror_en_r <= MIRROR_EN_RST;                            // [R24]
            afe_r       <= sfic_afe_t'(AFE_RST);
            mask_r      <= sfic_evt_t'(MASK_RST);
        end else begin
            if (wr_ena)
                led_en_r <= rx_byte[ENA_LED_BIT];
            if (mir_clr)
                mirror_en_r <= 1'b0;                                 // [R24]
            if (wr_afe)
                afe_r <= sfic_afe_t'(rx_byte[5:0]);                  // [R1]
            if (wr_mask)
                mask_r <= sfic_evt_t'(rx_byte[6:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags and request pin
    wire [6:0] clr_w     = int_rd ? 7'h7f : 7'h00;                   // [R14]
    wire [6:0] flags_nxt = (flags_r & ~clr_w) | evt_s;               // [R13]
    wire       pin_nxt   = |(flags_nxt & ~mask_r)                    // [R16]
                         & (holdoff_r == '0) & ~int_rd;              // [R15]

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_r   <= '0;
            holdoff_r <= '0;
            irq_r     <= 1'b0;
        end else if (off_mode) begin
            flags_r   <= '0;
            holdoff_r <= '0;
            irq_r     <= 1'b0;
        end else begin
            flags_r <= sfic_evt_t'(flags_nxt);                       // [R4]
            irq_r   <= pin_nxt;                                      // [R13]
            if (int_rd)
                holdoff_r <= REARM_W'(REARM_CYC);                    // [R15]
            else if (holdoff_r != '0)
                holdoff_r <= REARM_W'(holdoff_r - 1'b1);
        end
    end

    assign event_request_pin_n_out    = 1'b0;
    assign event_request_pin_n_oe_out = irq_r;
    assign event_flags_out            = flags_r;
    assign event_mask_out             = mask_r;

    ////////////////////////////////////////////////////////////////////////
    // Rail control and operating mode
    wire rails_nxt = ppr_s & mirror_en_r & ~mir_clr
                   & ~evt_s.thermal_shutdown_flag                    // [R5]
                   & ~evt_s.supply_undervoltage_lockout;             // [R9]
    wire led_nxt   = rails_nxt & led_en_r
                   & ~evt_s.six_volt_power_fail;                     // [R11]
    logic [7:0] onehot_w;
    sfic_mode_t mode_nxt;

    always_comb begin
        case (1'b1)
            off_mode:   mode_nxt = MODE_OFF;
            ~rails_nxt: mode_nxt = MODE_STANDBY;                     // [R8]
            ~led_nxt:   mode_nxt = MODE_ACTIVE1;
            default:    mode_nxt = MODE_ACTIVE2;
        endcase
    end

    sfic_sel_decode u_dec (
        .sel_in     (afe_r.measure_input_select),
        .onehot_out (onehot_w)
    );

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rails_r <= 1'b0;
            led_r   <= 1'b0;
            mode_r  <= MODE_OFF;
            chan_r  <= 8'h00;
        end else begin
            rails_r <= rails_nxt;                                    // [R6]
            led_r   <= led_nxt;                                      // [R12]
            mode_r  <= mode_nxt;
            chan_r  <= onehot_w;                                     // [R1]
        end
    end

    assign mirror_rails_enable_out = mirror_en_r;
    assign mirror_rails_on_out     = rails_r;
    assign led_driver_on_out       = led_r;
    assign mode_out                = mode_r;
    assign measure_channel_out     = chan_r;
    assign afe_config_out          = afe_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    property p_mux_select;                                           // [R1]
        rst_b_in |=> chan_r == (8'h01 << $past(afe_r.measure_input_select));
    endproperty
    a_mux_select: assert property (p_mux_select)                     // [R1]
        else $error("measure channel does not follow select");

    property p_flag_set;                                             // [R13]
        (~off_mode && evt_s != '0) |=> ((flags_r & $past(evt_s))
                                        == $past(evt_s));
    endproperty
    a_flag_set: assert property (p_flag_set)                         // [R13]
        else $error("event did not set its flag");

    sequence s_flag_read;
        ~off_mode && int_rd;
    endsequence
    property p_read_clear;                                           // [R14]
        s_flag_read |=> (flags_r == $past(evt_s) && !irq_r)
                        ##1 !irq_r [*7];
    endproperty
    a_read_clear: assert property (p_read_clear)                     // [R14]
        else $error("flag read did not clear flags or release pin");

    property p_rearm;                                                // [R15]
        s_flag_read ##1 ((flags_r & ~mask_r) != '0) |->
            ##[1:801] (irq_r || off_mode || ((flags_r & ~mask_r) == '0));
    endproperty
    a_rearm: assert property (p_rearm)                               // [R15]
        else $error("persisting fault did not pull pin low in time");

    property p_mask_gate;                                            // [R16]
        ((flags_nxt & ~mask_r) == '0) |=> !irq_r;
    endproperty
    a_mask_gate: assert property (p_mask_gate)                       // [R16]
        else $error("masked event drove request pin");

    property p_thermal_off;                                          // [R5]
        evt_s.thermal_shutdown_flag |=> !rails_r && !led_r;
    endproperty
    a_thermal_off: assert property (p_thermal_off)                   // [R5]
        else $error("rails on during thermal shutdown");

    property p_cell_warn;                                            // [R7]
        (ppr_s && mirror_en_r && !wr_ena
         && evt_s == sfic_evt_t'(7'h04)) |=> rails_r;
    endproperty
    a_cell_warn: assert property (p_cell_warn)                       // [R7]
        else $error("cell voltage warning stopped the rails");

    property p_mirror_fault;                                         // [R10]
        (~off_mode && evt_s.mirror_rail_fault) |=> !mirror_en_r ##1
            !rails_r && !led_r;
    endproperty
    a_mirror_fault: assert property (p_mirror_fault)                 // [R10]
        else $error("mirror fault did not stop rails");

    property p_supply_undervoltage_lockout_standby;                                         // [R8]
        (ppr_s && evt_s.supply_undervoltage_lockout) |=>
            mode_r == MODE_STANDBY;
    endproperty
    a_supply_undervoltage_lockout_standby: assert property (p_supply_undervoltage_lockout_standby)                 // [R8]
        else $error("lockout did not enter standby");

    property p_cs_idle;                                              // [R18]
        cs_n_s |-> !spi_dout_oe_out && !wr_stb;
    endproperty
    a_cs_idle: assert property (p_cs_idle)                           // [R18]
        else $error("serial port active with chip select high");

endmodule

//--- verification/sfic_host_model.sv
`timescale 1ns/1ps
module sfic_host_model (
    // Clock
    input  wire logic clk_in,
    // Serial port, host side
    output logic      chip_select_n_out,
    output logic      spi_clk_out,
    output logic      spi_din_out,
    input  wire logic spi_dout_in,
    input  wire logic spi_dout_oe_in
);
    logic last_r = 1'b0;
    logic miso;

    // Released line shows the inverse of its last driven level
    assign miso = spi_dout_oe_in ? spi_dout_in : ~last_r;

    always_ff @(posedge clk_in) begin
        if (spi_dout_oe_in) begin
            last_r <= spi_dout_in;
        end
    end

    initial begin
        chip_select_n_out = 1'b1;
        spi_clk_out = 1'b0;
        spi_din_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Command byte then n data bytes; sel low leaves chip select high
    task automatic frame(input logic sel, input logic [7:0] cmd,
                         input int n, input logic [7:0] wd [4],
                         output logic [7:0] rd [4]);
        logic [7:0] tx;
        logic [7:0] rx;
        @(posedge clk_in);
        chip_select_n_out <= ~sel;
        wait_clk(4);
        for (int b = 0; b <= n; b++) begin
            tx = (b == 0) ? cmd : wd[b-1];
            for (int i = 7; i >= 0; i--) begin
                spi_din_out <= tx[i];
                wait_clk(4);
                spi_clk_out <= 1'b1;
                rx[i] = miso;
                wait_clk(4);
                spi_clk_out <= 1'b0;
            end
            if (b > 0) begin
                rd[b-1] = rx;
            end
        end
        wait_clk(4);
        chip_select_n_out <= 1'b1;
        wait_clk(8);
    endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import sfic_pkg::*;
;
    logic       clk_in       = 1'b0;
    logic       rst_b_in     = 1'b0;
    logic       request      = 1'b0;
    sfic_evt_t  events       = '0;
    logic       cs_n;
    logic       sclk;
    logic       mosi;
    logic       dout;
    logic       dout_oe;
    logic       irq_n;
    logic       irq_oe;
    logic       mir_en;
    logic       rails_on;
    logic       led_on;
    sfic_mode_t mode;
    logic [7:0] channel;
    sfic_afe_t  afe;
    sfic_evt_t  flags;
    sfic_evt_t  mask;
    int         num_errors   = 0;
    int         total_checks = 0;
    logic [7:0] wd [4];
    logic [7:0] rdv [4];
    // Per event: {rails, led, mirror enable} during, {rails, led} after
    localparam logic [4:0] EXP [7] = '{5'h1f, 5'h07, 5'h1f, 5'h00,
                                       5'h00, 5'h17, 5'h1f};

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    spi_fault_interrupt_control dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .chip_select_n_in(cs_n), .spi_clk_in(sclk), .spi_din_in(mosi),
        .spi_dout_out(dout), .spi_dout_oe_out(dout_oe),
        .projector_power_request_in(request),
        .monitor_events_in(events),
        .event_request_pin_n_out(irq_n),
        .event_request_pin_n_oe_out(irq_oe),
        .mirror_rails_enable_out(mir_en), .mirror_rails_on_out(rails_on),
        .led_driver_on_out(led_on), .mode_out(mode),
        .measure_channel_out(channel), .afe_config_out(afe),
        .event_flags_out(flags), .event_mask_out(mask));

    sfic_host_model host (
        .clk_in(clk_in), .chip_select_n_out(cs_n), .spi_clk_out(sclk),
        .spi_din_out(mosi), .spi_dout_in(dout), .spi_dout_oe_in(dout_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic wait_irq(input int bound);
        int n;
        n = 0;
        while (irq_oe !== 1'b1 && n < bound) begin
            @(posedge clk_in);
            n++;
        end
        if (irq_oe !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: pin wait got %0h expected 1",
                     $time, irq_oe);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        wd[0] = d;
        host.frame(1'b1, {1'b1, a}, 1, wd, rdv);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        host.frame(1'b1, {1'b0, a}, 1, wd, rdv);
        d = rdv[0];
    endtask

    // Off mode ignores the port and restores defaults
    task automatic power_cycle();
        @(posedge clk_in);
        request <= 1'b0;
        wait_clk(6);
        wr(ADDR_AFE, 8'h3f);
        check(mode, MODE_OFF);
        @(posedge clk_in);
        request <= 1'b1;
        wait_clk(8);
        check({mir_en, afe}, 7'h40);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] v;
        check({irq_n, irq_oe, flags, mask, afe}, '0);
        check({mir_en, rails_on, led_on, mode}, {3'h7, MODE_ACTIVE2});
        rd(ADDR_ENABLE, v);
        check(v, 8'h03);
        $display("t_reset done");
    endtask

    task automatic t_mux();
        logic [1:0] g;
        logic [7:0] v;
        for (int s = 0; s < 8; s++) begin
            g = (s < 4) ? 2'h1 : (s == 4) ? 2'h3 : 2'h2;
            wr(ADDR_AFE, {2'h0, s >= 4, g, 3'(s)});
            wait_clk(2);
            check(channel, 8'h01 << s);
            check(afe, {s >= 4, g, 3'(s)});
        end
        rd(ADDR_AFE, v);
        check(v, 8'h37);
        wd[0] = 8'h00;
        host.frame(1'b0, 8'h8a, 1, wd, rdv);
        check({dout_oe, afe}, 7'h37);
        $display("t_mux done");
    endtask

    task automatic t_wrap();
        logic [7:0] v;
        wd = '{8'hff, 8'hff, 8'h01, 8'h00};
        host.frame(1'b1, 8'hff, 3, wd, rdv);
        check({mir_en, afe, mode}, {7'h37, MODE_STANDBY});
        rd(ADDR_ENABLE, v);
        check(v, 8'h01);
        power_cycle();
        $display("t_wrap done");
    endtask

    task automatic t_events();
        logic [7:0] v;
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in);
            events <= sfic_evt_t'(7'h01 << i);
            wait_irq(900);
            wait_clk(4);
            check(flags, 7'h01 << i);
            check({rails_on, led_on, mir_en}, EXP[i][4:2]);
            if (i == 3) begin
                check(mode, MODE_STANDBY);
            end else if (i == 5) begin
                check(mode, MODE_ACTIVE1);
            end
            @(posedge clk_in);
            events <= '0;
            wait_clk(8);
            check({rails_on, led_on}, EXP[i][1:0]);
            rd(ADDR_FLAGS, v);
            check(v, 8'h01 << i);
            wait_clk(4);
            check({irq_oe, flags}, 8'h00);
            power_cycle();
        end
        $display("t_events done");
    endtask

    task automatic t_persist();
        logic [7:0] v;
        @(posedge clk_in);
        events <= sfic_evt_t'(7'h02);
        wait_irq(900);
        rd(ADDR_FLAGS, v);
        check(v, 8'h02);
        check({irq_oe, flags}, 8'h02);
        wait_irq(820);
        wr(ADDR_MASK, 8'h02);
        wait_clk(4);
        check({irq_oe, flags, rails_on}, 9'h004);
        rd(ADDR_FLAGS, v);
        wait_clk(900);
        check({irq_oe, flags, mir_en}, 9'h005);
        @(posedge clk_in);
        events <= '0;
        wait_clk(8);
        check(rails_on, 1'b1);
        rd(ADDR_FLAGS, v);
        check(v, 8'h02);
        rd(ADDR_MASK, v);
        check(v, 8'h02);
        wr(ADDR_MASK, 8'h00);
        wait_clk(4);
        check({irq_oe, flags, mask}, 15'h0000);
        $display("t_persist done");
    endtask

    initial begin
        wait_clk(4);
        rst_b_in <= 1'b1;
        request <= 1'b1;
        wait_clk(12);
        t_reset();
        t_mux();
        t_wrap();
        t_events();
        t_persist();
        end_of_test();
    end
endmodule
